//--- stc_pkg.sv
// package: offsets, fields, resets and encodings of the secure top control block
package stc_pkg;
    // ***********************************
    // register byte offsets
    // ***********************************
    localparam logic [11:0] ADDR_CTRL1 = 12'h000;
    localparam logic [11:0] ADDR_IDR0 = 12'h004;
    localparam logic [11:0] ADDR_IDR1 = 12'h008;
    localparam logic [11:0] ADDR_FAULT_STAT = 12'h00c;
    localparam logic [11:0] ADDR_S2C_BASE = 12'h100;
    localparam int ADDR_W = 12;
    localparam int NUM_S2C = 8;
    localparam int S2C_IDX_W = 3;
    localparam int S2C_IDX_LSB = 2;
    localparam logic [11:0] S2C_SPAN = 12'h020;
    // ***********************************
    // implemented resources
    // ***********************************
    localparam logic [7:0] IMPL_IRQS = 8'h10;
    localparam logic [7:0] IMPL_GROUPS = 8'h08;
    localparam logic [7:0] IMPL_BANKS = 8'h08;
    localparam logic [7:0] IMPL_S2_BANKS = 8'h02;
    // implemented width of the three override fields; upper bits read as zero
    localparam logic [7:0] IRQ_MASK = 8'h1f;
    localparam logic [7:0] GRP_MASK = 8'h0f;
    localparam logic [7:0] BANK_MASK = 8'h0f;
    // ***********************************
    // control register fields
    // ***********************************
    localparam int PERF_BIT = 27;
    localparam int FETCH_BIT = 26;
    localparam int EXTRED_BIT = 25;
    localparam int GREST_BIT = 24;
    localparam int IRQ_LSB = 16;
    localparam int GRP_LSB = 8;
    localparam int BANK_LSB = 0;
    localparam logic [31:0] CTRL_WMASK = 32'h0fffffff;
    // ***********************************
    // mapping entry fields
    // ***********************************
    localparam int TYPE_LSB = 16;
    localparam logic [31:0] S2C_FAULT_WMASK = 32'h00030000;
    localparam logic [1:0] RESET_TYPE = 2'h2;
    typedef enum logic [1:0] {
        S2C_TRANSLATE = 2'h0,
        S2C_BYPASS = 2'h1,
        S2C_FAULT = 2'h2,
        S2C_RESERVED = 2'h3
    } stc_entry_type;
    // ***********************************
    // fault status bits and routing
    // ***********************************
    localparam int FS_CTX = 0;
    localparam int FS_SEC = 1;
    localparam int FS_NS = 2;
    localparam int FS_PERM = 3;
    localparam int FS_INVCTX = 4;
    typedef enum logic [2:0] {
        DEST_CTX = 3'h1,
        DEST_SEC = 3'h2,
        DEST_NS = 3'h4
    } stc_dest_type;
endpackage : stc_pkg

//--- stc_bus_if.sv
// interface: register write/read strobes between the bus slave and the register file
`timescale 1ns/1ps
`default_nettype none
interface stc_bus_if;
    logic wrEn;
    logic rdEn;
    logic secure;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [11:0] waddr;
    logic wsecure;
    modport slave (output wrEn, output rdEn, output secure, output addr, output wdata, input rdata,
        output waddr, output wsecure);
    modport regs (input wrEn, input rdEn, input secure, input addr, input wdata, output rdata,
        input waddr, input wsecure);
endinterface : stc_bus_if
`default_nettype wire

//--- stc_ahb_slave.sv
// module: ahb-lite slave front end turning bus phases into register strobes
`timescale 1ns/1ps
`default_nettype none
module stc_ahb_slave (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hprot1,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    stc_bus_if.slave bus
);
    import stc_pkg::*;
    logic wrPend_r;
    logic [11:0] addr_r;
    logic sec_r;
    logic take;
    // nonseq or seq, selected, previous transfer done
    assign take = hsel && htrans[1] && hready;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPend_r <= 1'b0;
            addr_r <= 12'h000;
            sec_r <= 1'b0;
        end else begin
            wrPend_r <= take && hwrite;
            if (take) begin
                addr_r <= haddr[11:0];
                // hprot[1] high means privileged; it is taken as the secure world here
                sec_r <= hprot1;
            end
        end
    end
    // reads decode in the address phase so data is registered for the data phase
    assign bus.rdEn = take && !hwrite;
    assign bus.wrEn = wrPend_r;
    // a write data phase can overlap the next read address phase, so each has its own address
    assign bus.secure = hprot1;
    assign bus.addr = haddr[11:0];
    assign bus.waddr = addr_r;
    assign bus.wsecure = sec_r;
    assign bus.wdata = hwdata;
    assign hrdata = bus.rdata;
    // zero wait states; every answer is okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule : stc_ahb_slave
`default_nettype wire

//--- stc_regs.sv
// module: secure top control register, mapping entries and fault router
// ***********************************
// Summary of operation
// - vm tag field reads zero, writes ignored
// - secure vm tag contents are disregarded
// - fault-type entry raises invalid-context fault
// - type decode: index, bypass, fault, reserved
// - control register accepts secure accesses only
// - perf enable gates secure event counting
// - fetch check faults secure non-secure fetches
// - faults go to context, secure global or non-secure global
// - redirect moves external aborts outside a translating context bank to secure global
// - restrict bit admits only secure accesses to the mapping entries
// - interrupt override resets to implemented count
// - nonsecure group count reduced by override
// - group override resets to implemented count
// - nonsecure bank count reduced by override
// - banks at or above override reserved for secure
// - bank override resets to implemented banks
// - no stage-2 translation for secure transactions
// ***********************************
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module stc_regs (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hprot1,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic txnValid,
    input wire logic [2:0] txnGroup,
    input wire logic txnSecure,
    input wire logic txnFetch,
    input wire logic txnOutNs,
    input wire logic txnInBank,
    input wire logic [7:0] txnBank,
    input wire logic txnExtAbort,
    input wire logic txnStage2,
    input wire logic perfEventIn,
    input wire logic perfEventSecure,
    output logic perfEventOut,
    output logic faultValid,
    output logic [2:0] faultDest,
    output logic [1:0] entryType,
    output logic secureBankAccess
);
    import stc_pkg::*;
    stc_bus_if bus ();
    stc_ahb_slave u_slave (
        .clk(clk),
        .resetn(resetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hprot1(hprot1),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .bus(bus)
    );
    // ***********************************
    // control register
    // ***********************************
    logic perfEn_r;
    logic fetchChk_r;
    logic extRedir_r;
    logic globRestrict_r;
    logic [7:0] irqOvr_r;
    logic [7:0] grpOvr_r;
    logic [7:0] bankOvr_r;
    logic [1:0] entType_r [NUM_S2C];
    logic [4:0] faultStat_r;
    logic [31:0] rdata_r;
    logic ctrlWr;
    logic s2cHit;
    logic [2:0] s2cIdx;
    logic s2cWrHit;
    logic [2:0] s2cWrIdx;
    function automatic logic isS2c(input logic [11:0] a);
        return (a >= ADDR_S2C_BASE) && (a < ADDR_S2C_BASE + S2C_SPAN);
    endfunction : isS2c
    function automatic logic [7:0] clampMin(input logic [7:0] a, input logic [7:0] b);
        return (a < b) ? a : b;
    endfunction : clampMin
    assign ctrlWr = bus.wrEn && bus.wsecure && (bus.waddr == ADDR_CTRL1);
    assign s2cHit = isS2c(bus.addr);
    assign s2cIdx = bus.addr[S2C_IDX_LSB +: S2C_IDX_W];
    assign s2cWrHit = isS2c(bus.waddr);
    assign s2cWrIdx = bus.waddr[S2C_IDX_LSB +: S2C_IDX_W];
    always_ff @(posedge clk) begin
        if (!resetn) begin
            perfEn_r <= 1'b0;
            fetchChk_r <= 1'b0;
            // reset value is undefined; zero chosen
            extRedir_r <= 1'b0;
            globRestrict_r <= 1'b0;
            irqOvr_r <= IMPL_IRQS & IRQ_MASK;
            grpOvr_r <= IMPL_GROUPS & GRP_MASK;
            bankOvr_r <= IMPL_BANKS & BANK_MASK;
        end else if (ctrlWr) begin
            perfEn_r <= bus.wdata[PERF_BIT];
            fetchChk_r <= bus.wdata[FETCH_BIT];
            extRedir_r <= bus.wdata[EXTRED_BIT];
            globRestrict_r <= bus.wdata[GREST_BIT];
            irqOvr_r <= bus.wdata[IRQ_LSB +: 8] & IRQ_MASK;
            grpOvr_r <= bus.wdata[GRP_LSB +: 8] & GRP_MASK;
            // software keeps this at or above the stage-2 bank count
            bankOvr_r <= bus.wdata[BANK_LSB +: 8] & BANK_MASK;
        end
    end
    // ***********************************
    // mapping entries
    // ***********************************
    // only the type field is stored; the rest of the fault format reads zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_S2C; i++) begin
                entType_r[i] <= RESET_TYPE;
            end
        end else if (bus.wrEn && s2cWrHit && !(globRestrict_r && !bus.wsecure)) begin
            entType_r[s2cWrIdx] <= bus.wdata[TYPE_LSB +: 2];
        end
    end
    // ***********************************
    // read data
    // ***********************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_r <= 32'h00000000;
        end else if (bus.rdEn) begin
            rdata_r <= 32'h00000000;
            case (bus.addr)
                ADDR_CTRL1: begin
                    if (bus.secure) begin
                        rdata_r <= {4'h0, perfEn_r, fetchChk_r, extRedir_r, globRestrict_r,
                                    irqOvr_r, grpOvr_r, bankOvr_r};
                    end
                end
                ADDR_IDR0: begin
                    rdata_r[GRP_LSB +: 8] <= bus.secure ? IMPL_GROUPS : clampMin(IMPL_GROUPS, grpOvr_r);
                end
                ADDR_IDR1: begin
                    rdata_r[BANK_LSB +: 8] <= bus.secure ? IMPL_BANKS : clampMin(IMPL_BANKS, bankOvr_r);
                    rdata_r[GRP_LSB +: 8] <= IMPL_S2_BANKS;
                end
                ADDR_FAULT_STAT: begin
                    rdata_r[4:0] <= faultStat_r;
                end
                default: begin
                    // restricted global space hides entries from non-secure
                    if (s2cHit && !(globRestrict_r && !bus.secure)) begin
                        rdata_r[TYPE_LSB +: 2] <= entType_r[s2cIdx];
                    end
                end
            endcase
        end
    end
    assign bus.rdata = rdata_r;
    // ***********************************
    // transaction checks and fault routing
    // ***********************************
    logic [1:0] curType;
    logic faultInv;
    logic faultPerm;
    logic faultAny;
    logic [2:0] dest;
    // secure vm tag not consulted; only the type selects behaviour
    assign curType = entType_r[txnGroup];
    always_comb begin
        faultInv = 1'b0;
        case (curType)
            S2C_TRANSLATE: faultInv = 1'b0;
            S2C_BYPASS: faultInv = 1'b0;
            S2C_FAULT: faultInv = 1'b1;
            // reserved type treated as fault to stay safe
            S2C_RESERVED: faultInv = 1'b1;
            default: faultInv = 1'b1;
        endcase
        if (txnSecure && txnStage2 && curType == S2C_TRANSLATE) begin
            faultInv = 1'b1;
        end
    end
    assign faultPerm = fetchChk_r && txnSecure && txnFetch && txnOutNs;
    assign faultAny = txnValid && (faultInv || faultPerm || txnExtAbort);
    always_comb begin
        if (txnInBank && curType == S2C_TRANSLATE) begin
            dest = DEST_CTX;
        end else if (txnSecure || faultPerm) begin
            dest = DEST_SEC;
        end else if (txnExtAbort && extRedir_r) begin
            dest = DEST_SEC;
        end else begin
            dest = DEST_NS;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            faultValid <= 1'b0;
            faultDest <= 3'h0;
            entryType <= 2'h0;
            faultStat_r <= 5'h00;
        end else begin
            faultValid <= faultAny;
            faultDest <= faultAny ? dest : 3'h0;
            entryType <= curType;
            // sticky; a new event wins over a clear in the same cycle
            faultStat_r <= (ctrlWr ? 5'h00 : faultStat_r)
                | (faultAny ? {faultInv, faultPerm, dest[2], dest[1], dest[0]} : 5'h00);
        end
    end
    assign perfEventOut = perfEventIn && (!perfEventSecure || perfEn_r);
    // banks at or above override are secure-reserved
    assign secureBankAccess = txnBank >= bankOvr_r;
endmodule : stc_regs
`default_nettype wire

//--- stc_regs_assertions.sv
// checker: port-level properties of the secure top control block
`timescale 1ns/1ps
`default_nettype none
module stc_regs_assertions (
    input wire logic clk,
    input wire logic resetn,
    input wire logic txnValid,
    input wire logic txnSecure,
    input wire logic txnInBank,
    input wire logic [7:0] txnBank,
    input wire logic txnStage2,
    input wire logic perfEventIn,
    input wire logic perfEventSecure,
    input wire logic perfEventOut,
    input wire logic faultValid,
    input wire logic [2:0] faultDest,
    input wire logic [1:0] entryType,
    input wire logic secureBankAccess
);
    import stc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_perf_ns_passes: assert property (perfEventIn && !perfEventSecure |-> perfEventOut)
        else $error("non-secure event dropped");
    a_perf_needs_event: assert property (!perfEventIn |-> !perfEventOut)
        else $error("event out without event in");
    a_fault_has_cause: assert property (faultValid |-> $past(txnValid))
        else $error("fault without transaction");
    a_fault_dest_onehot: assert property (faultValid |-> $onehot(faultDest))
        else $error("fault destination not one-hot");
    a_fault_type_raises: assert property ($past(txnValid) && entryType[1] |-> faultValid)
        else $error("fault-type entry gave no fault");
    a_ctx_needs_bank: assert property (faultValid && faultDest == DEST_CTX |-> $past(txnInBank))
        else $error("context fault outside a bank");
    a_sec_no_stage2: assert property ($past(txnValid && txnSecure && txnStage2)
        && entryType == S2C_TRANSLATE |-> faultValid)
        else $error("secure stage-2 translation allowed");
    // override field holds at most four bits, so higher banks are always secure
    a_bank_high_secure: assert property (txnBank > BANK_MASK |-> secureBankAccess)
        else $error("high bank not reserved");
endmodule : stc_regs_assertions
bind stc_regs stc_regs_assertions chk_u (.clk(clk), .resetn(resetn), .txnValid(txnValid), .txnSecure(txnSecure),
    .txnInBank(txnInBank), .txnBank(txnBank), .txnStage2(txnStage2), .perfEventIn(perfEventIn),
    .perfEventSecure(perfEventSecure), .perfEventOut(perfEventOut), .faultValid(faultValid),
    .faultDest(faultDest), .entryType(entryType), .secureBankAccess(secureBankAccess));
`default_nettype wire

//--- tb.sv
// testbench: register, routing and gating checks of the secure control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import stc_pkg::*;
    logic clk, resetn, hsel, hwrite, hprot1, txnValid, txnSecure, txnFetch, txnOutNs, txnInBank;
    logic txnExtAbort, txnStage2, perfEventIn, perfEventSecure, perfEventOut, faultValid;
    logic hreadyout, hresp, secureBankAccess;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, entryType;
    logic [2:0] hsize, txnGroup, faultDest;
    logic [7:0] txnBank;
    wire hready;
    int n_mismatch = 0;
    int tests_run = 0;
    localparam logic [31:0] CTRL_RST = {8'h0, IMPL_IRQS & IRQ_MASK, IMPL_GROUPS & GRP_MASK, IMPL_BANKS & BANK_MASK};
    // single slave: its ready is the bus ready
    assign hready = hreadyout;
    stc_regs dut_u (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hprot1(hprot1), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .txnValid(txnValid), .txnGroup(txnGroup), .txnSecure(txnSecure), .txnFetch(txnFetch),
        .txnOutNs(txnOutNs), .txnInBank(txnInBank), .txnBank(txnBank), .txnExtAbort(txnExtAbort),
        .txnStage2(txnStage2), .perfEventIn(perfEventIn), .perfEventSecure(perfEventSecure),
        .perfEventOut(perfEventOut), .faultValid(faultValid), .faultDest(faultDest), .entryType(entryType),
        .secureBankAccess(secureBankAccess));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // ***********************************
    // bus and compare helpers
    // ***********************************
    task automatic stop_test;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'h1) begin
            n++;
            if (n > 20) begin
                n_mismatch++;
                $display("[ERR] %0t bus hang", $time);
                stop_test;
            end
            @(posedge clk);
        end
    endtask : wait_rdy
    // leaves one idle cycle before the next call, so a read never sees a stale write
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic sec);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= wr;
        hprot1 <= sec;
        wait_rdy;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask : bus
    task automatic txn(input logic [2:0] g, input logic [5:0] f);
        @(posedge clk);
        txnValid <= 1'h1;
        txnGroup <= g;
        {txnSecure, txnFetch, txnOutNs, txnInBank, txnExtAbort, txnStage2} <= f;
        @(posedge clk);
        txnValid <= 1'h0;
        #1;
    endtask : txn
    task automatic chk_fault(input logic v, input logic [2:0] d);
        chk({31'h0, faultValid}, {31'h0, v});
        if (v) begin
            chk({29'h0, faultDest}, {29'h0, d});
        end
    endtask : chk_fault
    // ***********************************
    // scenarios
    // ***********************************
    task automatic t_reset;
        bus(1'h0, ADDR_CTRL1, 32'h0, 1'h1);
        chk(rd, CTRL_RST);
        for (int i = 0; i < NUM_S2C; i++) begin
            bus(1'h0, ADDR_S2C_BASE + {7'h0, 3'(i), 2'h0}, 32'h0, 1'h1);
            chk(rd, {14'h0, RESET_TYPE, 16'h0});
        end
    endtask : t_reset
    task automatic t_ctrl;
        bus(1'h1, ADDR_CTRL1, 32'hffffffff, 1'h0);
        bus(1'h0, ADDR_CTRL1, 32'h0, 1'h0);
        chk(rd, 32'h0);
        bus(1'h0, ADDR_CTRL1, 32'h0, 1'h1);
        chk(rd, CTRL_RST);
        bus(1'h1, ADDR_CTRL1, 32'hffffffff, 1'h1);
        bus(1'h0, ADDR_CTRL1, 32'h0, 1'h1);
        chk(rd, {8'h0f, IRQ_MASK, GRP_MASK, BANK_MASK});
    endtask : t_ctrl
    task automatic t_override;
        bus(1'h1, ADDR_CTRL1, 32'h00100403, 1'h1);
        bus(1'h0, ADDR_IDR0, 32'h0, 1'h0);
        chk({24'h0, rd[15:8]}, 32'h4);
        bus(1'h0, ADDR_IDR1, 32'h0, 1'h0);
        chk({24'h0, rd[7:0]}, 32'h3);
        bus(1'h0, ADDR_IDR1, 32'h0, 1'h1);
        chk({24'h0, rd[7:0]}, {24'h0, IMPL_BANKS});
        // override 3 kept above stage-2 count
        chk({24'h0, rd[15:8]}, {24'h0, IMPL_S2_BANKS});
        bus(1'h0, ADDR_IDR0, 32'h0, 1'h1);
        chk({24'h0, rd[15:8]}, {24'h0, IMPL_GROUPS});
        @(posedge clk);
        txnBank <= 8'h03;
        #1;
        chk({31'h0, secureBankAccess}, 32'h1);
        @(posedge clk);
        txnBank <= 8'h02;
        #1;
        chk({31'h0, secureBankAccess}, 32'h0);
        @(posedge clk);
        txnBank <= 8'h20;
        #1;
        chk({31'h0, secureBankAccess}, 32'h1);
    endtask : t_override
    task automatic t_perf;
        @(posedge clk);
        perfEventIn <= 1'h1;
        perfEventSecure <= 1'h0;
        #1;
        chk({31'h0, perfEventOut}, 32'h1);
        @(posedge clk);
        perfEventSecure <= 1'h1;
        #1;
        chk({31'h0, perfEventOut}, 32'h0);
        bus(1'h1, ADDR_CTRL1, 32'h08100403, 1'h1);
        #1;
        chk({31'h0, perfEventOut}, 32'h1);
    endtask : t_perf
    task automatic t_entry;
        for (int t = 0; t < 4; t++) begin
            bus(1'h1, ADDR_S2C_BASE + {7'h0, 3'(t), 2'h0}, {14'h3fff, 2'(t), 16'hffff}, 1'h1);
            bus(1'h0, ADDR_S2C_BASE + {7'h0, 3'(t), 2'h0}, 32'h0, 1'h1);
            chk(rd, {14'h0, 2'(t), 16'h0});
            txn(3'(t), 6'h00);
            chk({30'h0, entryType}, 32'(t));
            chk_fault(t >= 2, DEST_NS);
        end
    endtask : t_entry
    task automatic t_route;
        bus(1'h1, ADDR_CTRL1, 32'h04100403, 1'h1);
        txn(3'h0, 6'b111000);
        chk_fault(1'h1, DEST_SEC);
        txn(3'h0, 6'b000110);
        chk_fault(1'h1, DEST_CTX);
        txn(3'h0, 6'b000010);
        chk_fault(1'h1, DEST_NS);
        txn(3'h0, 6'b100001);
        chk_fault(1'h1, DEST_SEC);
        bus(1'h1, ADDR_CTRL1, 32'h02100403, 1'h1);
        txn(3'h0, 6'b111000);
        chk_fault(1'h0, DEST_SEC);
        txn(3'h0, 6'b000010);
        chk_fault(1'h1, DEST_SEC);
        bus(1'h0, ADDR_FAULT_STAT, 32'h0, 1'h1);
        chk(rd, 32'h1 << FS_SEC);
    endtask : t_route
    task automatic t_restrict;
        bus(1'h1, ADDR_CTRL1, 32'h01100403, 1'h1);
        // no hypervisor bank while restrict toggles
        bus(1'h1, ADDR_S2C_BASE + 12'h004, 32'h00030000, 1'h0);
        bus(1'h0, ADDR_S2C_BASE + 12'h004, 32'h0, 1'h1);
        chk(rd, 32'h00010000);
        bus(1'h0, ADDR_S2C_BASE + 12'h004, 32'h0, 1'h0);
        chk(rd, 32'h0);
        bus(1'h1, ADDR_CTRL1, 32'h00100403, 1'h1);
        bus(1'h1, ADDR_S2C_BASE + 12'h004, 32'h00030000, 1'h0);
        bus(1'h0, ADDR_S2C_BASE + 12'h004, 32'h0, 1'h0);
        chk(rd, 32'h00030000);
    endtask : t_restrict
    initial begin
        resetn = 1'h0;
        {hsel, hwrite, hprot1, htrans, haddr, hwdata} = 69'h0;
        hsize = 3'h2;
        {txnValid, txnSecure, txnFetch, txnOutNs, txnInBank, txnExtAbort, txnStage2} = 7'h0;
        {perfEventIn, perfEventSecure, txnGroup, txnBank} = 13'h0;
        repeat (8) @(posedge clk);
        resetn <= 1'h1;
        t_reset;
        t_ctrl;
        t_override;
        t_perf;
        t_entry;
        t_route;
        t_restrict;
        stop_test;
    end
endmodule : tb
`default_nettype wire
